// ==== core/pmlhc_pkg.sv ====
`default_nettype none

package pmlhc_pkg;

    // apb register map, byte addresses
    localparam int          ADDR_WIDTH       = 8;
    localparam logic [7:0]  REG_CHAN_MODE    = 8'h00;
    localparam logic [7:0]  REG_POWER_STATUS = 8'h04;
    localparam logic [7:0]  REG_INT_STATUS   = 8'h08;
    localparam logic [7:0]  REG_INT_MASK     = 8'h0C;
    localparam logic [7:0]  REG_XFER_STATUS  = 8'h10;

    localparam int          NUM_CHANNELS     = 4;
    localparam int          MODE_BITS        = 2;
    localparam int          CHAN_MODE_WIDTH  = NUM_CHANNELS * MODE_BITS;

    // per-channel control mode codes
    localparam logic [1:0]  MODE_OFF_NODIAG  = 2'h0;
    localparam logic [1:0]  MODE_FOLLOW_PIN  = 2'h1;
    localparam logic [1:0]  MODE_FORCED_ON   = 2'h2;
    localparam logic [1:0]  MODE_OFF_DIAG    = 2'h3;
    localparam logic [7:0]  CHAN_MODE_RESET  = 8'h00;

    // power status field positions
    localparam int          PS_MODE_LSB      = 0;
    localparam int          PS_TER_PENDING   = 2;
    localparam int          PS_TER_FLAG      = 3;
    localparam int          PS_HOLD_ON       = 4;
    localparam int          PS_SLEEP_PIN     = 5;
    localparam int          PS_FAIL_PIN      = 6;
    localparam int          PS_INPUT_LSB     = 8;

    // xfer status field positions
    localparam int          XS_EDGES_LSB     = 0;
    localparam int          XS_COUNT_LSB     = 16;
    localparam int          EDGE_CNT_WIDTH   = 8;
    localparam int          XFER_CNT_WIDTH   = 16;

    // interrupt bit positions
    localparam int          NUM_IRQ          = 4;
    localparam int          IRQ_FS_ENTER     = 0;
    localparam int          IRQ_FS_EXIT      = 1;
    localparam int          IRQ_TER          = 2;
    localparam int          IRQ_SLEEP        = 3;
    localparam logic [3:0]  INT_MASK_RESET   = 4'h0;

    // synchroniser reset levels: fs, sleep_n, cs_n, sclk, in[3:0]
    localparam logic [7:0]  SYNC_RESET       = 8'h60;

    typedef enum logic [1:0] {
        PM_SLEEP,
        PM_IDLE,
        PM_ON,
        PM_FAIL_SAFE
    } pmlhc_power_type;

    function automatic logic chan_drive(input logic [1:0] mode, input logic pin);
        logic result;
        result = 1'b0;
        if (mode == MODE_FORCED_ON) begin
            result = 1'b1;
        end else if (mode == MODE_FOLLOW_PIN) begin
            result = pin;
        end
        return result;
    endfunction

    function automatic logic chan_diag(input logic [1:0] mode);
        return mode != MODE_OFF_NODIAG;
    endfunction

endpackage

`default_nettype wire

// ==== core/pmlhc_sync.sv ====
`default_nettype none

module pmlhc_sync #(
    parameter int               WIDTH       = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // stage1 feeds only stage2
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // pmlhc_sync

`default_nettype wire

// ==== core/pmlhc_power_mode_and_limp_home_control.sv ====
// The APB interface to the registers and the placing of the registers were decided locally.
`default_nettype none

// Behaviour
// - power-on reset returns all registers to defaults, then idle mode.
// - low sleep reset pin forces the channel mode register to defaults and sleep mode.
// - idle keeps every channel off with no diagnosis active.
// - high fail-safe select pin enters fail-safe and resets the channel mode register.
// - in fail-safe each input pin drives the same-index output directly.
// - in fail-safe serial commands are ignored; outputs follow pins only.
// - fail-safe request beats sleep reset pin and wakes the device.
// - every transfer during fail-safe returns a set transfer error flag.
// - leaving fail-safe resets the channel mode register, then sleep or on with diagnosis.
// - first transfer after fail-safe ends also returns the error flag.
// - four channel modes: off, follow pin, forced on, off with diagnosis.
// - all channels off without diagnosis drops the device into idle, except while held on after fail-safe.
// - following channel: high pin means on, low pin means off.
// - unconnected input pin reads low, switching its channel off.
module pmlhc_power_mode_and_limp_home_control (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [pmlhc_pkg::ADDR_WIDTH-1:0]      paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic                                  sleep_reset_pin_n,
    input  wire logic                                  fail_safe_select_pin,
    input  wire logic [pmlhc_pkg::NUM_CHANNELS-1:0]    channel_input_pin,
    input  wire logic                                  chip_select_n,
    input  wire logic                                  serial_clock,
    output logic      [pmlhc_pkg::NUM_CHANNELS-1:0]    channel_output,
    output logic      [pmlhc_pkg::NUM_CHANNELS-1:0]    diag_current_enable,
    output logic                                       transfer_error_flag,
    output logic      [1:0]                            power_mode,
    output logic                                       irq
);

    localparam int NCH = pmlhc_pkg::NUM_CHANNELS;

    // synchronised pins
    logic [7:0]                                pin_sync;
    logic                                      s_fail_safe;
    logic                                      s_sleep_n;
    logic                                      s_cs_n;
    logic                                      s_sclk;
    logic [NCH-1:0]                            s_in;

    // state
    pmlhc_pkg::pmlhc_power_type                state;
    pmlhc_pkg::pmlhc_power_type                next_state;
    logic [pmlhc_pkg::CHAN_MODE_WIDTH-1:0]     chan_mode;
    logic [pmlhc_pkg::CHAN_MODE_WIDTH-1:0]     next_chan_mode;
    logic                                      hold_on;
    logic                                      next_hold_on;
    logic                                      ter_pending;
    logic                                      next_ter_pending;
    logic                                      next_ter_flag;
    logic                                      cs_prev;
    logic                                      sclk_prev;
    logic [pmlhc_pkg::EDGE_CNT_WIDTH-1:0]      edge_cnt;
    logic [pmlhc_pkg::EDGE_CNT_WIDTH-1:0]      last_edges;
    logic [pmlhc_pkg::XFER_CNT_WIDTH-1:0]      xfer_cnt;
    logic [pmlhc_pkg::NUM_IRQ-1:0]             int_status;
    logic [pmlhc_pkg::NUM_IRQ-1:0]             next_int_status;
    logic [pmlhc_pkg::NUM_IRQ-1:0]             int_mask;
    logic [pmlhc_pkg::NUM_IRQ-1:0]             events;
    logic [NCH-1:0]                            next_out;
    logic [NCH-1:0]                            next_diag;

    // decode
    wire in_fs       = (state == pmlhc_pkg::PM_FAIL_SAFE);
    wire fs_enter    = !in_fs && s_fail_safe;
    wire leave_fs    = in_fs && !s_fail_safe;
    wire regs_reset  = s_fail_safe || !s_sleep_n || leave_fs;
    wire all_off     = (chan_mode == pmlhc_pkg::CHAN_MODE_RESET);
    // diag must rise on the very edge that leaves fail-safe, not one later
    wire diag_hold   = hold_on || leave_fs;
    // frame edges on the synchronised chip select
    wire xfer_start  = cs_prev && !s_cs_n;
    wire xfer_end    = !cs_prev && s_cs_n;
    wire sclk_rise   = !sclk_prev && s_sclk && !s_cs_n;
    wire ter_now     = in_fs || s_fail_safe ||
                       ter_pending || leave_fs;

    // apb: answer one cycle after setup, never stretched
    wire apb_setup   = psel && !penable;
    wire apb_access  = psel && penable && pready;
    wire apb_write   = apb_access && pwrite && !pslverr;
    wire sel_mode    = (paddr == pmlhc_pkg::REG_CHAN_MODE);
    wire sel_power   = (paddr == pmlhc_pkg::REG_POWER_STATUS);
    wire sel_istat   = (paddr == pmlhc_pkg::REG_INT_STATUS);
    wire sel_imask   = (paddr == pmlhc_pkg::REG_INT_MASK);
    wire sel_xfer    = (paddr == pmlhc_pkg::REG_XFER_STATUS);
    wire addr_hit    = sel_mode || sel_power || sel_istat || sel_imask || sel_xfer;
    wire mode_write  = apb_write && sel_mode && !in_fs && !regs_reset;
    wire [pmlhc_pkg::NUM_IRQ-1:0] w1c =
        (apb_write && sel_istat) ? pwdata[pmlhc_pkg::NUM_IRQ-1:0] : '0;

    // pin-side inputs, reset level of channel pins is low
    pmlhc_sync #(
        .WIDTH       (8),
        .RESET_VALUE (pmlhc_pkg::SYNC_RESET)
    ) u_pin_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in ({fail_safe_select_pin,
                    sleep_reset_pin_n,
                    chip_select_n,
                    serial_clock,
                    channel_input_pin}),
        .sync_out (pin_sync)
    );

    assign s_fail_safe = pin_sync[7];
    assign s_sleep_n   = pin_sync[6];
    assign s_cs_n      = pin_sync[5];
    assign s_sclk      = pin_sync[4];
    assign s_in        = pin_sync[3:0];

    // power mode selection
    always_comb begin
        if (s_fail_safe) begin
            next_state = pmlhc_pkg::PM_FAIL_SAFE;
        end else if (in_fs) begin
            next_state = s_sleep_n ? pmlhc_pkg::PM_ON : pmlhc_pkg::PM_SLEEP;
        end else if (!s_sleep_n) begin
            next_state = pmlhc_pkg::PM_SLEEP;
        end else if (state == pmlhc_pkg::PM_SLEEP || (all_off && !hold_on)) begin
            next_state = pmlhc_pkg::PM_IDLE;
        end else begin
            next_state = pmlhc_pkg::PM_ON;
        end
    end

    // mode register: cleared by every reset source
    assign next_chan_mode = regs_reset ? pmlhc_pkg::CHAN_MODE_RESET :
                            mode_write ? pwdata[pmlhc_pkg::CHAN_MODE_WIDTH-1:0] :
                            chan_mode;

    // after fail-safe the device sits in on mode until software reprograms or the sleep pin goes low
    assign next_hold_on = (leave_fs && s_sleep_n) ? 1'b1 :
                          (mode_write || !s_sleep_n) ? 1'b0 : hold_on;

    // error flag for the next transfer; setting wins over clearing
    assign next_ter_pending = leave_fs ? 1'b1 :
                              (xfer_start && !ter_now) ? 1'b0 :
                              (xfer_start && !in_fs && !s_fail_safe) ? 1'b0 :
                              ter_pending;

    // flag stands for the whole frame; fail-safe mid-frame also marks it
    assign next_ter_flag = xfer_start ? ter_now :
                           (s_cs_n && !xfer_start) ? 1'b0 :
                           (transfer_error_flag || in_fs || s_fail_safe);

    // channel multiplexer
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            wire [1:0] mode = chan_mode[ch*2 +: 2];
            assign next_out[ch] =
                (next_state == pmlhc_pkg::PM_FAIL_SAFE) ? s_in[ch] :
                (next_state == pmlhc_pkg::PM_ON) ?
                    pmlhc_pkg::chan_drive(mode, s_in[ch]) :
                1'b0;
            assign next_diag[ch] = (next_state == pmlhc_pkg::PM_ON) &&
                (diag_hold || pmlhc_pkg::chan_diag(mode));
        end
    endgenerate

    // interrupt sources: one-cycle pulses, each latched in a sticky bit
    assign events[pmlhc_pkg::IRQ_FS_ENTER] = fs_enter;
    assign events[pmlhc_pkg::IRQ_FS_EXIT]  = leave_fs;
    assign events[pmlhc_pkg::IRQ_TER]      = xfer_start && ter_now;
    assign events[pmlhc_pkg::IRQ_SLEEP]    = (state != pmlhc_pkg::PM_SLEEP) &&
                                             (next_state == pmlhc_pkg::PM_SLEEP);
    // an event in the clearing cycle survives
    assign next_int_status = (int_status & ~w1c) | events;

    // read mux
    logic [31:0] power_word;
    logic [31:0] xfer_word;
    logic [31:0] read_word;
    always_comb begin
        power_word = '0;
        power_word[pmlhc_pkg::PS_MODE_LSB +: 2]      = state;
        power_word[pmlhc_pkg::PS_TER_PENDING]        = ter_pending;
        power_word[pmlhc_pkg::PS_TER_FLAG]           = transfer_error_flag;
        power_word[pmlhc_pkg::PS_HOLD_ON]            = hold_on;
        power_word[pmlhc_pkg::PS_SLEEP_PIN]          = s_sleep_n;
        power_word[pmlhc_pkg::PS_FAIL_PIN]           = s_fail_safe;
        power_word[pmlhc_pkg::PS_INPUT_LSB +: NCH]   = s_in;
        xfer_word = '0;
        xfer_word[pmlhc_pkg::XS_EDGES_LSB +: pmlhc_pkg::EDGE_CNT_WIDTH] = last_edges;
        xfer_word[pmlhc_pkg::XS_COUNT_LSB +: pmlhc_pkg::XFER_CNT_WIDTH] = xfer_cnt;
        read_word = '0;
        if (sel_mode) begin
            read_word[pmlhc_pkg::CHAN_MODE_WIDTH-1:0] = chan_mode;
        end else if (sel_power) begin
            read_word = power_word;
        end else if (sel_istat) begin
            read_word[pmlhc_pkg::NUM_IRQ-1:0] = int_status;
        end else if (sel_imask) begin
            read_word[pmlhc_pkg::NUM_IRQ-1:0] = int_mask;
        end else if (sel_xfer) begin
            read_word = xfer_word;
        end
    end

    // power-on reset lands in idle with defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= pmlhc_pkg::PM_IDLE;
            power_mode  <= 2'h1;
            chan_mode   <= pmlhc_pkg::CHAN_MODE_RESET;
            hold_on     <= 1'b0;
        end else begin
            state       <= next_state;
            power_mode  <= next_state;
            chan_mode   <= next_chan_mode;
            hold_on     <= next_hold_on;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_output      <= '0;
            diag_current_enable <= '0;
        end else begin
            channel_output      <= next_out;
            diag_current_enable <= next_diag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ter_pending         <= 1'b0;
            transfer_error_flag <= 1'b0;
            cs_prev             <= 1'b1;
            sclk_prev           <= 1'b0;
        end else begin
            ter_pending         <= next_ter_pending;
            transfer_error_flag <= next_ter_flag;
            cs_prev             <= s_cs_n;
            sclk_prev           <= s_sclk;
        end
    end

    // frame statistics; edges count only while chip select is low, frames at its rise
    // diagnostic only; never gates a mode change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt   <= '0;
            last_edges <= '0;
            xfer_cnt   <= '0;
        end else begin
            if (xfer_start) begin
                edge_cnt <= '0;
            end else if (sclk_rise) begin
                edge_cnt <= edge_cnt + 1'b1;
            end
            if (xfer_end) begin
                last_edges <= edge_cnt;
                xfer_cnt   <= xfer_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
            int_mask   <= pmlhc_pkg::INT_MASK_RESET;
            irq        <= 1'b0;
        end else begin
            int_status <= next_int_status;
            if (apb_write && sel_imask) begin
                int_mask <= pwdata[pmlhc_pkg::NUM_IRQ-1:0];
            end
            irq        <= |(next_int_status &
                           ((apb_write && sel_imask) ? pwdata[pmlhc_pkg::NUM_IRQ-1:0]
                                                     : int_mask));
        end
    end

    // one wait-free access: answer is registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup && !addr_hit;
            prdata  <= (apb_setup && !pwrite) ? read_word : '0;
        end
    end

endmodule // pmlhc_power_mode_and_limp_home_control

`default_nettype wire

// ==== verif/pmlhc_sva.sv ====
`default_nettype none

module pmlhc_sva (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       sleep_reset_pin_n,
    input wire logic       fail_safe_select_pin,
    input wire logic [3:0] channel_input_pin,
    input wire logic       chip_select_n,
    input wire logic [3:0] channel_output,
    input wire logic [3:0] diag_current_enable,
    input wire logic       transfer_error_flag,
    input wire logic [1:0] power_mode
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_POR_IDLE: assert property ($rose(presetn) |-> power_mode == 2'h1)
        else $error("mode not idle after reset");
    AST_QUIET_OFF: assert property (power_mode inside {2'h0, 2'h1} |->
        channel_output == 4'h0 && diag_current_enable == 4'h0)
        else $error("channel active in sleep or idle");
    AST_SLEEP_PIN: assert property ((!sleep_reset_pin_n && !fail_safe_select_pin) [*4]
        |-> power_mode == 2'h0)
        else $error("sleep pin low but not asleep");
    AST_FS_PRIO: assert property (fail_safe_select_pin [*4] |-> power_mode == 2'h3)
        else $error("fail-safe pin high but mode differs");
    AST_FS_ROUTE: assert property ((power_mode == 2'h3 && $stable(channel_input_pin)) [*4]
        |-> channel_output == channel_input_pin)
        else $error("fail-safe outputs differ from pins");
    AST_FS_TER: assert property ((power_mode == 2'h3 && !chip_select_n) [*5]
        |-> transfer_error_flag)
        else $error("no error flag in fail-safe frame");
    AST_EXIT_ON: assert property ($past(power_mode) == 2'h3 && power_mode != 2'h3 |->
        power_mode == 2'h0 ||
        (power_mode == 2'h2 && channel_output == 4'h0 && diag_current_enable == 4'hF))
        else $error("bad state after leaving fail-safe");
    // flag must fall once the frame is over, whatever the mode
    AST_TER_CLEAR: assert property (chip_select_n [*4] |-> !transfer_error_flag)
        else $error("error flag outside a frame");

    COV_FS_FRAME: cover property (power_mode == 2'h3 && !chip_select_n);
    COV_EXIT: cover property ($past(power_mode) == 2'h3 && power_mode == 2'h2);
    COV_SLEEP: cover property (power_mode == 2'h0);
endmodule // pmlhc_sva

bind pmlhc_power_mode_and_limp_home_control pmlhc_sva i_pmlhc_sva (
    .pclk, .presetn, .sleep_reset_pin_n, .fail_safe_select_pin, .channel_input_pin,
    .chip_select_n, .channel_output, .diag_current_enable, .transfer_error_flag, .power_mode
);

`default_nettype wire

// ==== verif/pmlhc_spi_master.sv ====
`default_nettype none

module pmlhc_spi_master (
    input  wire logic go,
    output logic      chip_select_n,
    output logic      serial_clock,
    output logic      busy
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        chip_select_n = 1'b1;
        serial_clock  = 1'b0;
        busy          = 1'b0;
    end

    // clock stands low between frames; one 8-bit frame per rising go
    always @(posedge go) begin
        busy = 1'b1;
        chip_select_n = 1'b0;
        // offset keeps every serial clock edge and the chip select rise off the pclk edges
        #310;
        repeat (8) begin
            serial_clock = 1'b1;
            #200;
            serial_clock = 1'b0;
            #200;
        end
        #300;
        chip_select_n = 1'b1;
        #400;
        busy = 1'b0;
    end
endmodule // pmlhc_spi_master

`default_nettype wire

// ==== verif/pmlhc_power_mode_and_limp_home_control_tb.sv ====
`default_nettype none

module pmlhc_power_mode_and_limp_home_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        sleep_reset_pin_n, fail_safe_select_pin, chip_select_n, serial_clock;
    logic [3:0]  channel_input_pin, channel_output, diag_current_enable;
    logic        transfer_error_flag, irq, rerr, go, busy;
    logic [1:0]  power_mode;
    int          n_errors, n_compared, cycles;

    pmlhc_power_mode_and_limp_home_control i_pmlhc_power_mode_and_limp_home_control (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sleep_reset_pin_n, .fail_safe_select_pin, .channel_input_pin,
        .chip_select_n, .serial_clock, .channel_output, .diag_current_enable,
        .transfer_error_flag, .power_mode, .irq);
    pmlhc_spi_master i_pmlhc_spi_master (.go, .chip_select_n, .serial_clock, .busy);

    task automatic conclude;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        forever begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic pins(input logic fs, input logic sl, input logic [3:0] inp);
        fail_safe_select_pin <= fs;
        sleep_reset_pin_n <= sl;
        channel_input_pin <= inp;
        repeat (4) @(posedge pclk);
    endtask

    task automatic outs(input logic [1:0] m, input logic [3:0] o, input logic [3:0] dg);
        chk({22'h0, power_mode, channel_output, diag_current_enable}, {22'h0, m, o, dg});
    endtask

    task automatic frame(input logic exp);
        go <= 1'b1;
        repeat (40) @(posedge pclk);
        chk({31'h0, transfer_error_flag}, {31'h0, exp});
        while (busy === 1'b1) @(posedge pclk);
        go <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic t_reset;
        outs(2'h1, 4'h0, 4'h0);
        apb(1'b0, pmlhc_pkg::REG_CHAN_MODE, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, rerr}, 32'h1);
    endtask

    task automatic t_modes;
        // ch0 follow, ch1 forced on, ch2 off with diag, ch3 off
        apb(1'b1, pmlhc_pkg::REG_CHAN_MODE, 32'h39);
        pins(1'b0, 1'b1, 4'h0);
        outs(2'h2, 4'h2, 4'h7);
        pins(1'b0, 1'b1, 4'hF);
        outs(2'h2, 4'h3, 4'h7);
        apb(1'b0, pmlhc_pkg::REG_CHAN_MODE, 32'h0);
        chk(rdata, 32'h39);
        apb(1'b1, pmlhc_pkg::REG_CHAN_MODE, 32'h0);
        repeat (3) @(posedge pclk);
        outs(2'h1, 4'h0, 4'h0);
    endtask

    task automatic t_fail_safe;
        apb(1'b1, pmlhc_pkg::REG_INT_MASK, 32'h1);
        apb(1'b1, pmlhc_pkg::REG_CHAN_MODE, 32'h2);
        pins(1'b0, 1'b0, 4'hA);
        outs(2'h0, 4'h0, 4'h0);
        apb(1'b1, pmlhc_pkg::REG_CHAN_MODE, 32'hAA);
        apb(1'b0, pmlhc_pkg::REG_CHAN_MODE, 32'h0);
        chk(rdata, 32'h0);
        pins(1'b1, 1'b0, 4'hA);
        outs(2'h3, 4'hA, 4'h0);
        chk({31'h0, irq}, 32'h1);
        pins(1'b1, 1'b1, 4'h5);
        apb(1'b1, pmlhc_pkg::REG_CHAN_MODE, 32'h55);
        apb(1'b0, pmlhc_pkg::REG_CHAN_MODE, 32'h0);
        chk(rdata, 32'h0);
        outs(2'h3, 4'h5, 4'h0);
        frame(1'b1);
        apb(1'b1, pmlhc_pkg::REG_INT_STATUS, 32'hF);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_exit;
        pins(1'b0, 1'b1, 4'hF);
        outs(2'h2, 4'h0, 4'hF);
        frame(1'b1);
        frame(1'b0);
        apb(1'b0, pmlhc_pkg::REG_XFER_STATUS, 32'h0);
        chk(rdata, (32'h3 << pmlhc_pkg::XS_COUNT_LSB) | (32'h8 << pmlhc_pkg::XS_EDGES_LSB));
        pins(1'b1, 1'b0, 4'hF);
        pins(1'b0, 1'b0, 4'hF);
        outs(2'h0, 4'h0, 4'h0);
        pins(1'b0, 1'b1, 4'h0);
        outs(2'h1, 4'h0, 4'h0);
    endtask

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // no test should come near this many cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, fail_safe_select_pin, go} = 6'h00;
        {paddr, pwdata, channel_input_pin} = 44'h0;
        sleep_reset_pin_n = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_modes();
        t_fail_safe();
        t_exit();
        conclude();
    end
endmodule // pmlhc_power_mode_and_limp_home_control_tb

`default_nettype wire
